// ---- design/user_config_word0_loader.sv ----
// Loader that fetches the first configuration word and applies its fields
`timescale 1ns/1ps
module user_config_word0_loader
	import cfg_loader_pkg::*;
(
	input wire logic i_clk_sys, // System clock, 250 MHz
	input wire logic i_rst_n, // Any reset source, active low
	// Flash configuration area read port
	output logic o_flash_req, // Read request, held until valid
	output logic [23:0] o_flash_addr, // Read address
	input wire logic i_flash_valid, // Read data valid, one cycle
	input wire logic [31:0] i_flash_rdata, // Read data
	// Avalon-MM slave
	input wire logic [7:0] i_avs_address, // Byte address
	input wire logic i_avs_read, // Read request
	input wire logic i_avs_write, // Write request
	input wire logic [31:0] i_avs_writedata, // Write data
	input wire logic [3:0] i_avs_byteenable, // Byte lanes
	output logic [31:0] o_avs_readdata, // Read data
	output logic o_avs_waitrequest, // Stall
	// Controls towards clock, watchdog, brown-out and PWM logic
	input wire logic i_lirc_en, // Oscillator enable bit from power control
	output logic o_cpu_rst_hold, // CPU held in reset while high
	output logic o_wdt_enable, // Watchdog enabled
	output logic o_wdt_clk_lirc, // Watchdog clock forced to 10 kHz RC
	output logic o_lirc_run, // 10 kHz RC oscillator request
	output logic [2:0] o_clk_src, // System clock select
	output logic o_bod_enable, // Brown-out detection enabled
	output logic [12:0] o_bod_level_mv, // Brown-out threshold in mV
	output logic o_bod_reset_enable, // Brown-out reset enabled
	output logic [TRI_W-1:0] o_pwm_tristate // Port tri-state per group
);

	////////////////////////////////////////////////////////////////////
	// Load sequence

	load_state_e state_q, state_d;
	logic [31:0] word_q, word_d;
	logic wdt_en_q, lirc_force_q, clk_rsv_q, bod_en_q, bod_rst_q;
	logic [12:0] bod_mv_q;
	logic [TRI_W-1:0] tri_cfg_q, poen_q, poen_d;
	logic [2:0] clk_sel_q, clk_sel_d;

	wire dec_wdt_en;
	wire dec_lirc_force;
	wire [2:0] dec_clk_src;
	wire dec_clk_rsv;
	wire dec_bod_en;
	wire [12:0] dec_bod_mv;
	wire dec_bod_rst;
	wire [TRI_W-1:0] dec_tri;

	cfg_word_decode u_decode (
		.i_word(word_q),
		.i_lirc_en(i_lirc_en),
		.o_wdt_en(dec_wdt_en),
		.o_lirc_force(dec_lirc_force),
		.o_lirc_run(),
		.o_clk_src(dec_clk_src),
		.o_clk_rsv(dec_clk_rsv),
		.o_bod_en(dec_bod_en),
		.o_bod_mv(dec_bod_mv),
		.o_bod_rst_en(dec_bod_rst),
		.o_tri(dec_tri)
	);

	wire in_fetch = (state_q == ST_FETCH);
	wire in_apply = (state_q == ST_APPLY);
	wire load_done = (state_q == ST_DONE);
	wire fetch_hit = in_fetch & i_flash_valid;

	always_comb begin
		case (state_q)
			ST_FETCH: state_d = i_flash_valid ? ST_APPLY : ST_FETCH;
			ST_APPLY: state_d = ST_DONE;
			ST_DONE: state_d = ST_DONE;
			default: state_d = ST_FETCH;
		endcase
	end

	// Word is captured once per reset; later flash rewrites are not seen
	assign word_d = fetch_hit ? i_flash_rdata : word_q;

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= ST_FETCH;
			word_q <= CFG_WORD_RST;
		end else begin
			state_q <= state_d;
			word_q <= word_d;
		end
	end

	// Derived controls latched in the apply cycle only
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wdt_en_q <= 1'b0;
			lirc_force_q <= 1'b0;
			clk_rsv_q <= 1'b0;
			bod_en_q <= 1'b0;
			bod_mv_q <= BOD_MV_00;
			bod_rst_q <= 1'b0;
			tri_cfg_q <= PWM_POEN_RST;
		end else if (in_apply) begin
			wdt_en_q <= dec_wdt_en;
			lirc_force_q <= dec_lirc_force;
			clk_rsv_q <= dec_clk_rsv;
			bod_en_q <= dec_bod_en;
			bod_mv_q <= dec_bod_mv;
			bod_rst_q <= dec_bod_rst;
			tri_cfg_q <= dec_tri;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Avalon-MM slave

	logic ack_q;
	logic [31:0] rdata_q;

	wire bus_req = i_avs_read | i_avs_write;
	wire bus_take = bus_req & ~ack_q & load_done;
	wire wr_take = bus_take & i_avs_write & i_avs_byteenable[0];
	wire sel_clk = (i_avs_address == REG_CLK_SEL0);
	wire sel_poen = (i_avs_address == REG_PWM_POEN);
	wire [31:0] status_word = {30'h0, clk_rsv_q, load_done};
	wire [31:0] rd_mux = (i_avs_address == REG_CFG_WORD) ? word_q :
		(i_avs_address == REG_STATUS) ? status_word :
		sel_clk ? {29'h0, clk_sel_q} :
		sel_poen ? {27'h0, poen_q} : 32'h0;

	// The apply cycle after each reset copies config fields into the select and port control regs
	assign clk_sel_d = in_apply ? dec_clk_src :
		(wr_take & sel_clk) ? i_avs_writedata[2:0] : clk_sel_q;
	assign poen_d = in_apply ? dec_tri :
		(wr_take & sel_poen) ? i_avs_writedata[TRI_W-1:0] : poen_q;

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ack_q <= 1'b0;
			rdata_q <= 32'h0;
			clk_sel_q <= CLK_SEL_RST;
			poen_q <= PWM_POEN_RST;
		end else begin
			ack_q <= bus_take;
			rdata_q <= (bus_take & i_avs_read) ? rd_mux : rdata_q;
			clk_sel_q <= clk_sel_d;
			poen_q <= poen_d;
		end
	end

	assign o_avs_waitrequest = bus_req & ~ack_q;
	assign o_avs_readdata = rdata_q;

	////////////////////////////////////////////////////////////////////
	// Outputs

	assign o_flash_req = in_fetch;
	assign o_flash_addr = CFG_WORD0_ADDR;
	assign o_cpu_rst_hold = ~load_done;
	assign o_wdt_enable = wdt_en_q;
	assign o_wdt_clk_lirc = wdt_en_q;
	assign o_lirc_run = lirc_force_q | i_lirc_en;
	assign o_clk_src = clk_sel_q;
	assign o_bod_enable = bod_en_q;
	assign o_bod_level_mv = bod_mv_q;
	assign o_bod_reset_enable = bod_rst_q;
	// A set config bit keeps its group tri-state whatever software writes
	assign o_pwm_tristate = poen_q | tri_cfg_q;

	////////////////////////////////////////////////////////////////////
	// Assertion helpers

	logic fetch_seen_q;
	logic [TRI_W-1:0] wr_low_q;

	// Marks a taken flash word until reset; samples the low write data bits every cycle
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			fetch_seen_q <= 1'b0;
			wr_low_q <= {TRI_W{1'b0}};
		end else begin
			fetch_seen_q <= fetch_seen_q | fetch_hit;
			wr_low_q <= i_avs_writedata[TRI_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);

	a_cpu_hold_load: assert property (
		$fell(o_cpu_rst_hold) |-> o_clk_src == word_q[CLK_SRC_LSB +: 3] &&
			o_pwm_tristate == word_q[TRI_LSB +: TRI_W])
		else $error("CPU released before configuration applied");

	a_apply_then_release: assert property (
		fetch_hit |=> in_apply ##1 (load_done && !o_cpu_rst_hold))
		else $error("Load sequence did not release CPU in two cycles");

	a_clk_sel_copy: assert property (
		in_apply |=> o_clk_src == word_q[CLK_SRC_LSB +: 3])
		else $error("Clock select not loaded from config word");

	a_poen_copy: assert property (
		in_apply |=> poen_q == word_q[TRI_LSB +: TRI_W])
		else $error("Port control not loaded from config word");

	a_tri_forced: assert property (
		load_done |-> (o_pwm_tristate & word_q[TRI_LSB +: TRI_W]) ==
			word_q[TRI_LSB +: TRI_W])
		else $error("Configured tri-state group is driven");

	a_wdt_bod_ctrl: assert property (
		load_done |-> o_wdt_enable == !word_q[WDT_DIS_POS] &&
			o_bod_enable == !word_q[BOD_DIS_POS] &&
			o_bod_reset_enable == !word_q[BOD_RST_DIS_POS])
		else $error("Watchdog or brown-out control mismatch");

	a_lirc_gate: assert property (
		load_done |-> o_lirc_run == (i_lirc_en ||
			(!word_q[WDT_DIS_POS] && !word_q[WDT_PDGATE_POS])))
		else $error("10 kHz clock request wrong");

	a_bod_level: assert property (
		load_done && word_q[BOD_LVL_LSB +: 2] == 2'h3 |->
			o_bod_level_mv == BOD_MV_11)
		else $error("Brown-out threshold decode wrong");

	a_clk_reserved: assert property (
		load_done |-> clk_rsv_q == !(word_q[CLK_SRC_LSB +: 3] == 3'h0 ||
			word_q[CLK_SRC_LSB +: 3] == 3'h7))
		else $error("Reserved clock code flag wrong");

	a_word_frozen: assert property (
		load_done |=> $stable(word_q) && $stable(tri_cfg_q))
		else $error("Config word changed without reboot");

	a_bus_answer: assert property (
		bus_req && load_done && !ack_q |=> !o_avs_waitrequest)
		else $error("Bus answer late");

	a_bod_level_map: assert property (
		load_done |-> o_bod_level_mv ==
			((word_q[BOD_LVL_LSB +: 2] == 2'h0) ? BOD_MV_00 :
			(word_q[BOD_LVL_LSB +: 2] == 2'h1) ? BOD_MV_01 :
			(word_q[BOD_LVL_LSB +: 2] == 2'h2) ? BOD_MV_10 : BOD_MV_11))
		else $error("Brown-out threshold map wrong");

	a_wdt_clk_force: assert property (
		load_done |-> o_wdt_clk_lirc == !word_q[WDT_DIS_POS])
		else $error("Watchdog clock not forced to the 10 kHz source");

	a_lirc_ignored: assert property (
		load_done && word_q[WDT_DIS_POS] |-> o_lirc_run == i_lirc_en)
		else $error("Power-down gate honoured with watchdog disabled");

	a_ctrl_before_apply: assert property (
		!load_done |-> o_clk_src == CLK_SEL_RST && !o_wdt_enable &&
			!o_bod_enable && o_pwm_tristate == PWM_POEN_RST)
		else $error("Controls moved before the word was applied");

	a_fetch_once: assert property (
		fetch_seen_q |-> !o_flash_req && !fetch_hit)
		else $error("Configuration word fetched twice in one reset");

	a_stall_before_done: assert property (
		!load_done && bus_req |-> o_avs_waitrequest)
		else $error("Bus answered before load finished");

	a_clk_write_lands: assert property (
		wr_take && sel_clk |=> o_clk_src == wr_low_q[2:0])
		else $error("Clock select write lost");

	a_poen_write_lands: assert property (
		wr_take && sel_poen |=> poen_q == wr_low_q)
		else $error("Port control write lost");

	a_lane_refused: assert property (
		bus_take && i_avs_write && !i_avs_byteenable[0] |=>
			$stable(clk_sel_q) && $stable(poen_q))
		else $error("Write without low byte lane took effect");

	a_rdata_hold: assert property (
		!(bus_take && i_avs_read) |=> $stable(o_avs_readdata))
		else $error("Read data moved without a taken read");

	a_ack_single: assert property (ack_q |=> !ack_q)
		else $error("Bus answer held for more than one cycle");

	// Clear config bit hands the group to the port control register
	for (genvar gi = 0; gi < TRI_W; gi++) begin : g_tri_chk
		a_tri_follow: assert property (
			load_done && !word_q[TRI_LSB + gi] |->
				o_pwm_tristate[gi] == poen_q[gi])
			else $error("Unforced tri-state group ignores port control");
	end

	c_load_done: cover property (fetch_hit ##2 load_done);
	c_bus_read: cover property (i_avs_read && !o_avs_waitrequest);
	c_clk_write: cover property (wr_take && sel_clk);
	c_wdt_forced: cover property (load_done && lirc_force_q && !i_lirc_en);
	c_clk_reserved: cover property (load_done && clk_rsv_q);

endmodule

// ---- design/cfg_loader_pkg.sv ----
// Constants, field layout and register map of the user configuration loader
//
// Contract
// - Watchdog bit 0 enables watchdog after power-on, clocked from 10 kHz RC.
// - Power-down gate 0 keeps 10 kHz clock on; 1 follows oscillator enable.
// - Power-down gate bit only matters while the watchdog bit is 0.
// - After any reset, clock source field is copied into clock select bits.
// - Clock code 000 is external crystal, 111 is fast RC, others reserved.
// - Brown-out detect bit 0 enables brown-out detection after power-on.
// - Threshold field 00/01/10/11 selects 2.2/2.7/3.7/4.4 volts.
// - Brown-out reset bit 0 enables brown-out reset after power-on.
// - Basic PWM tri-state bit 1 forces those ports tri-state permanently.
// - After any reset, basic PWM tri-state bit loads port control bit 4.
// - Unit1 odd tri-state bit 1 forces those ports tri-state permanently.
// - After any reset, unit1 odd tri-state bit loads port control bit 3.
// - Unit1 even tri-state bit 1 forces those ports tri-state permanently.
// - After any reset, unit1 even tri-state bit loads port control bit 2.
// - Unit0 odd tri-state bit 1 forces those ports tri-state permanently.
// - After any reset, unit0 odd tri-state bit loads port control bit 1.
// - Unit0 even tri-state bit 1 forces those ports tri-state permanently.
// - After any reset, unit0 even tri-state bit loads port control bit 0.
// - A rewritten configuration word takes effect only after the next reboot.
package cfg_loader_pkg;

	localparam logic [23:0] CFG_WORD0_ADDR = 24'h300000;

	// Field positions inside the configuration word
	localparam int WDT_DIS_POS = 31;
	localparam int WDT_PDGATE_POS = 30;
	localparam int CLK_SRC_LSB = 24;
	localparam int BOD_DIS_POS = 23;
	localparam int BOD_LVL_LSB = 21;
	localparam int BOD_RST_DIS_POS = 20;
	localparam int TRI_LSB = 8;
	localparam int TRI_W = 5;

	// Clock source codes
	localparam logic [2:0] CLK_SRC_XTAL = 3'h0;
	localparam logic [2:0] CLK_SRC_FRC = 3'h7;

	// Brown-out thresholds in millivolts
	localparam logic [12:0] BOD_MV_00 = 13'h0898;
	localparam logic [12:0] BOD_MV_01 = 13'h0A8C;
	localparam logic [12:0] BOD_MV_10 = 13'h0E74;
	localparam logic [12:0] BOD_MV_11 = 13'h1130;

	// Register byte offsets
	localparam logic [7:0] REG_CFG_WORD = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_CLK_SEL0 = 8'h08;
	localparam logic [7:0] REG_PWM_POEN = 8'h0C;

	// Status bit positions
	localparam int STAT_DONE_POS = 0;
	localparam int STAT_CLK_RSV_POS = 1;

	// Values after reset
	localparam logic [31:0] CFG_WORD_RST = 32'hFFFFFFFF;
	localparam logic [2:0] CLK_SEL_RST = 3'h7;
	localparam logic [4:0] PWM_POEN_RST = 5'h1F;

	typedef enum logic [1:0] {
		ST_FETCH = 2'b00,
		ST_APPLY = 2'b01,
		ST_DONE = 2'b10
	} load_state_e;

endpackage

// ---- design/cfg_word_decode.sv ----
// Combinational decode of the first user configuration word
`timescale 1ns/1ps
module cfg_word_decode
	import cfg_loader_pkg::*;
(
	input wire logic [31:0] i_word, // Latched configuration word
	input wire logic i_lirc_en, // Oscillator enable from power control
	output logic o_wdt_en, // Watchdog enabled
	output logic o_lirc_force, // 10 kHz clock forced on
	output logic o_lirc_run, // 10 kHz clock request
	output logic [2:0] o_clk_src, // CPU clock source code
	output logic o_clk_rsv, // Clock source code is reserved
	output logic o_bod_en, // Brown-out detection enabled
	output logic [12:0] o_bod_mv, // Brown-out threshold in mV
	output logic o_bod_rst_en, // Brown-out reset enabled
	output logic [TRI_W-1:0] o_tri // Tri-state configuration bits
);

	wire [1:0] bod_lvl = i_word[BOD_LVL_LSB +: 2];

	assign o_wdt_en = ~i_word[WDT_DIS_POS];
	assign o_lirc_force = o_wdt_en & ~i_word[WDT_PDGATE_POS];
	assign o_lirc_run = o_lirc_force | i_lirc_en;
	assign o_clk_src = i_word[CLK_SRC_LSB +: 3];
	assign o_clk_rsv = (o_clk_src != CLK_SRC_XTAL) &&
		(o_clk_src != CLK_SRC_FRC);
	assign o_bod_en = ~i_word[BOD_DIS_POS];
	assign o_bod_mv = (bod_lvl == 2'h0) ? BOD_MV_00 :
		(bod_lvl == 2'h1) ? BOD_MV_01 :
		(bod_lvl == 2'h2) ? BOD_MV_10 : BOD_MV_11;
	assign o_bod_rst_en = ~i_word[BOD_RST_DIS_POS];

	// Tri-state bits map straight onto port control bits 0..4
	genvar gi;
	generate
		for (gi = 0; gi < TRI_W; gi++) begin : g_tri
			assign o_tri[gi] = i_word[TRI_LSB + gi];
		end
	endgenerate

endmodule

// ---- testbench/flash_cfg_model.sv ----
// Flash configuration area model answering the loader's word fetch
`timescale 1ns/1ps
module flash_cfg_model (
	input wire logic i_clk, // System clock
	input wire logic i_rst_n, // Reset, active low
	input wire logic i_req, // Read request from loader
	input wire logic [31:0] i_word, // Word stored in flash
	input wire logic [7:0] i_delay, // Wait cycles before answering
	output logic o_valid, // Data valid, one cycle
	output logic [31:0] o_rdata // Read data
);
	logic [7:0] cnt_q;
	////////////////////////////////////////////////////////////////////////
	// Data toggles outside the valid cycle so stale values never match
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_q <= 8'h00;
			o_valid <= 1'b0;
			o_rdata <= 32'h00000000;
		end else if (i_req && !o_valid && cnt_q >= i_delay) begin
			cnt_q <= 8'h00;
			o_valid <= 1'b1;
			o_rdata <= i_word;
		end else begin
			cnt_q <= (i_req && !o_valid) ? cnt_q + 8'h01 : 8'h00;
			o_valid <= 1'b0;
			o_rdata <= ~o_rdata;
		end
	end
endmodule

// ---- testbench/test_user_config_word0_loader.sv ----
// Self-checking bench for the configuration word loader
`timescale 1ns/1ps
module test_user_config_word0_loader
	import cfg_loader_pkg::*;
;
	typedef struct {logic [31:0] w; logic l;} row_s;
	logic clk, rst_n, lirc, freq, fval, rd, wr, hold, wdt, wclk, run;
	logic bod, bodr, wreq;
	logic [31:0] word, frd, wdata, rdata, q;
	logic [23:0] faddr;
	logic [7:0] addr, dly;
	logic [3:0] be;
	logic [2:0] clk_src;
	logic [12:0] mv_out;
	logic [4:0] tri_out;
	int miscompares, checks_done;
	logic [12:0] mv [4] = '{BOD_MV_00, BOD_MV_01, BOD_MV_10, BOD_MV_11};
	row_s rows [4] = '{'{32'h00000000, 1'b0}, '{32'h47201500, 1'b0},
		'{32'hC3D00A00, 1'b1}, '{32'h80701F00, 1'b0}};
	////////////////////////////////////////////////////////////////////////
	user_config_word0_loader DUT (.i_clk_sys(clk), .i_rst_n(rst_n),
		.o_flash_req(freq), .o_flash_addr(faddr), .i_flash_valid(fval),
		.i_flash_rdata(frd), .i_avs_address(addr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
		.o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_lirc_en(lirc),
		.o_cpu_rst_hold(hold), .o_wdt_enable(wdt), .o_wdt_clk_lirc(wclk),
		.o_lirc_run(run), .o_clk_src(clk_src), .o_bod_enable(bod),
		.o_bod_level_mv(mv_out), .o_bod_reset_enable(bodr),
		.o_pwm_tristate(tri_out));
	flash_cfg_model flash (.i_clk(clk), .i_rst_n(rst_n), .i_req(freq),
		.i_word(word), .i_delay(dly), .o_valid(fval), .o_rdata(frd));
	////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		if (miscompares == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One Avalon access, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] b, output logic [31:0] r);
		int n;
		@(posedge clk);
		rd <= !w;
		wr <= w;
		addr <= a;
		wdata <= d;
		be <= b;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wreq !== 1'b0);
		r = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		chk(n < 100, 1'b1);
	endtask

	task automatic outs(input logic [31:0] w, input logic l);
		chk(wdt, !w[31]);
		chk(wclk, !w[31]);
		chk(run, !(w[31] | w[30]) | l);
		chk(clk_src, w[26:24]);
		chk(bod, !w[23]);
		chk(mv_out, mv[w[22:21]]);
		chk(bodr, !w[20]);
		chk(tri_out, w[12:8]);
	endtask

	task automatic boot(input logic [31:0] w, input logic l);
		int n;
		word <= w;
		lirc <= l;
		rst_n <= 1'b0;
		repeat (12) @(posedge clk);
		chk(hold, 1'b1);
		chk(clk_src, CLK_SEL_RST);
		chk(tri_out, PWM_POEN_RST);
		rst_n <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hold !== 1'b0 && n < 100);
		chk(hold, 1'b0);
		outs(w, l);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial begin
		#40000;
		miscompares++;
		finish_test();
	end

	initial begin
		rd = 1'b0;
		wr = 1'b0;
		addr = 8'h00;
		wdata = 32'h00000000;
		be = 4'hF;
		miscompares = 0;
		checks_done = 0;
		for (int i = 0; i < 4; i++) begin
			dly <= i[7:0];
			boot(rows[i].w, rows[i].l);
			bus(1'b0, REG_CFG_WORD, 32'h0, 4'hF, q);
			chk(q, rows[i].w);
			bus(1'b0, REG_STATUS, 32'h0, 4'hF, q);
			chk(q, {30'h0, rows[i].w[26:24] != 3'h0
				&& rows[i].w[26:24] != 3'h7, 1'b1});
			bus(1'b0, REG_CLK_SEL0, 32'h0, 4'hF, q);
			chk(q, {29'h0, rows[i].w[26:24]});
			bus(1'b0, REG_PWM_POEN, 32'h0, 4'hF, q);
			chk(q, {27'h0, rows[i].w[12:8]});
			lirc <= !rows[i].l;
			repeat (2) @(posedge clk);
			chk(run, !(rows[i].w[31] | rows[i].w[30]) | !rows[i].l);
		end
		lirc <= 1'b0;
		// Software writes, byte lanes, read-only and unmapped places
		bus(1'b1, REG_CLK_SEL0, 32'h5, 4'hF, q);
		chk(clk_src, 3'h5);
		bus(1'b1, REG_CLK_SEL0, 32'h2, 4'hE, q);
		chk(clk_src, 3'h5);
		bus(1'b1, REG_PWM_POEN, 32'h0, 4'hF, q);
		chk(tri_out, 5'h1F);
		bus(1'b1, REG_CFG_WORD, 32'h0, 4'hF, q);
		bus(1'b0, REG_CFG_WORD, 32'h0, 4'hF, q);
		chk(q, 32'h80701F00);
		bus(1'b0, 8'h20, 32'h0, 4'hF, q);
		chk(q, 32'h00000000);
		// Rewritten word waits for the next reboot
		bus(1'b1, REG_CLK_SEL0, 32'h0, 4'hF, q);
		word <= 32'h00000A00;
		repeat (20) @(posedge clk);
		outs(32'h80701F00, 1'b0);
		rst_n <= 1'b0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		bus(1'b0, REG_STATUS, 32'h0, 4'hF, q);
		chk(q, 32'h00000001);
		outs(32'h00000A00, 1'b0);
		bus(1'b0, REG_PWM_POEN, 32'h0, 4'hF, q);
		chk(q, 32'h0000000A);
		finish_test();
	end
endmodule
